// file: hdl/flash_host_pkg.sv
// Shared constants and types for the flash status-polling host controller
package flash_host_pkg;
	// ****************************************
	// Widths and timing
	// ****************************************
	localparam int ADDR_W = 17;
	localparam int CLK_NS = 25;
	localparam int T_STROBE_NS = 70;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC = 2;
	localparam logic [3:0] WR_LEN = 4'(STROBE_CYC);
	localparam logic [3:0] RD_LEN = 4'(STROBE_CYC + SYNC_CYC);
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_ABORT_BIT = 9;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_NACC = 3;
	localparam int ST_WIN = 4;
	localparam int ST_ACC = 5;
	localparam int ST_DATA_LSB = 8;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// ****************************************
	// Controller commands
	// ****************************************
	localparam logic [3:0] CMD_READ = 4'h0;
	localparam logic [3:0] CMD_PROG = 4'h1;
	localparam logic [3:0] CMD_CHIP = 4'h2;
	localparam logic [3:0] CMD_SECT = 4'h3;
	localparam logic [3:0] CMD_ADD = 4'h4;
	localparam logic [3:0] CMD_SUSPEND = 4'h5;
	localparam logic [3:0] CMD_RESUME = 4'h6;
	localparam logic [3:0] CMD_RESET = 4'h7;
	localparam logic [3:0] CMD_POLL = 4'h8;
	// ****************************************
	// Flash command cycles and status bits
	// ****************************************
	localparam logic [16:0] UNLOCK1_ADDR = 17'h00555;
	localparam logic [16:0] UNLOCK2_ADDR = 17'h002aa;
	localparam logic [16:0] ANY_ADDR = 17'h00000;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] PROG_DATA = 8'ha0;
	localparam logic [7:0] ERASE_DATA = 8'h80;
	localparam logic [7:0] CHIP_DATA = 8'h10;
	localparam logic [7:0] SECT_DATA = 8'h30;
	localparam logic [7:0] SUSP_DATA = 8'hb0;
	localparam logic [7:0] RESUME_DATA = 8'h30;
	localparam logic [7:0] RESET_DATA = 8'hf0;
	localparam int ACTIVITY_TOGGLE_BIT = 6;
	localparam int TIMEOUT_FAILURE_FLAG = 5;
	localparam int ERASE_WINDOW_BIT = 3;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [16:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} flash_pins_t;
	typedef struct packed {
		logic [16:0] addr;
		logic [7:0] data;
		logic last;
	} seq_step_t;
endpackage : flash_host_pkg

// file: hdl/flash_cycle.sv
// One read or write bus cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_cycle (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Cycle request
	input wire logic start,
	input wire logic wr,
	input wire logic [16:0] addr,
	input wire logic [7:0] wdata,
	// Cycle result
	output logic [7:0] rdata,
	output logic done,
	// Flash pins
	output flash_host_pkg::flash_pins_t pins,
	input wire logic [7:0] dq_in
);
	import flash_host_pkg::*;
	typedef enum {C_IDLE, C_SETUP, C_STROBE, C_REC} cyc_state_t;
	cyc_state_t state_reg, state_next;
	flash_pins_t pins_reg, pins_next;
	logic [7:0] rdata_reg, rdata_next;
	logic done_reg, done_next;
	logic [3:0] cnt_reg, cnt_next;
	logic wr_reg, wr_next;
	logic [7:0] dq_meta_reg, dq_sync_reg;
	// ****************************************
	// Cycle sequencing
	// ****************************************
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		rdata_next = rdata_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		done_next = 1'b0;
		case (state_reg)
			C_IDLE: if (start) begin
				pins_next.addr = addr;
				pins_next.dq_out = wdata;
				pins_next.dq_oe = wr;
				pins_next.ce_n = 1'b0;
				wr_next = wr;
				state_next = C_SETUP;
			end
			C_SETUP: begin
				pins_next.we_n = !wr_reg;
				pins_next.oe_n = wr_reg;
				cnt_next = 4'h1;
				state_next = C_STROBE;
			end
			C_STROBE: begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == (wr_reg ? WR_LEN : RD_LEN)) begin
					pins_next.we_n = 1'b1;
					pins_next.oe_n = 1'b1;
					if (!wr_reg) rdata_next = dq_sync_reg;
					state_next = C_REC;
				end
			end
			C_REC: begin
				pins_next.ce_n = 1'b1;
				pins_next.dq_oe = 1'b0;
				done_next = 1'b1;
				state_next = C_IDLE;
			end
			default: state_next = C_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= C_IDLE;
			pins_reg <= '{addr: 17'h00000, dq_out: 8'h00, dq_oe: 1'b0,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			rdata_reg <= 8'h00;
			done_reg <= 1'b0;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			dq_meta_reg <= 8'h00;
			dq_sync_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			rdata_reg <= rdata_next;
			done_reg <= done_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			dq_meta_reg <= dq_in;
			dq_sync_reg <= dq_meta_reg;
		end
	end
	assign pins = pins_reg;
	assign rdata = rdata_reg;
	assign done = done_reg;
	a_strobe_excl: assert property (@(posedge ref_clk) disable iff (rst)
		!(!pins_reg.oe_n && !pins_reg.we_n)) else $error("oe and we low together");
endmodule : flash_cycle
`default_nettype wire

// file: hdl/flash_host.sv
// Host controller that issues flash commands and runs the status polling procedure
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module flash_host (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Flash pins
	output flash_host_pkg::flash_pins_t flash_out,
	input wire logic [7:0] flash_dq_in
);
	import flash_host_pkg::*;
	typedef enum {S_IDLE, S_READ, S_PRE_WIN, S_SEQ, S_RD1, S_RD2, S_RD3, S_RD4,
		S_POST_WIN, S_RESET} host_state_t;

	function automatic logic accept_cmd(input logic [3:0] c);
		accept_cmd = (c == CMD_SECT) || (c == CMD_ADD);
	endfunction : accept_cmd

	function automatic seq_step_t seq_step(input logic [3:0] c, input logic [2:0] i,
		input logic [16:0] a, input logic [7:0] d);
		seq_step_t s;
		s = '{addr: UNLOCK1_ADDR, data: UNLOCK1_DATA, last: 1'b0};
		case (c)
			CMD_SUSPEND: s = '{addr: ANY_ADDR, data: SUSP_DATA, last: 1'b1};
			CMD_RESUME: s = '{addr: ANY_ADDR, data: RESUME_DATA, last: 1'b1};
			CMD_RESET: s = '{addr: ANY_ADDR, data: RESET_DATA, last: 1'b1};
			CMD_ADD: s = '{addr: a, data: SECT_DATA, last: 1'b1};
			default: case (i)
				3'h0: s.last = 1'b0;
				3'h1, 3'h4: s = '{addr: UNLOCK2_ADDR, data: UNLOCK2_DATA, last: 1'b0};
				3'h2: s.data = (c == CMD_PROG) ? PROG_DATA : ERASE_DATA;
				3'h3: if (c == CMD_PROG) s = '{addr: a, data: d, last: 1'b1};
				default: if (c == CMD_CHIP) s = '{addr: UNLOCK1_ADDR, data: CHIP_DATA, last: 1'b1};
					else s = '{addr: a, data: SECT_DATA, last: 1'b1};
			endcase
		endcase
		seq_step = s;
	endfunction : seq_step

	// ****************************************
	// AHB-Lite register slave
	// ****************************************
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wa_reg, wa_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [3:0] cmd_reg, cmd_next;
	logic [16:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic ctrl_wr, start;
	logic [31:0] stat_word;
	logic busy_reg, busy_next, done_reg, done_next, fail_reg, fail_next;
	logic nacc_reg, nacc_next, acc_reg, acc_next, win_reg, win_next;
	logic pre_win_reg, pre_win_next, abort_reg, abort_next, tog_reg, tog_next;
	logic issued_reg, issued_next;
	logic [7:0] last_rd_reg, last_rd_next;
	logic [2:0] step_reg, step_next;
	host_state_t state_reg, state_next;
	logic cyc_start, cyc_wr, cyc_done;
	logic [16:0] cyc_addr;
	logic [7:0] cyc_wdata, cyc_rdata;
	seq_step_t step_s;

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[ST_BUSY] = busy_reg;
		stat_word[ST_DONE] = done_reg;
		stat_word[ST_FAIL] = fail_reg;
		stat_word[ST_NACC] = nacc_reg;
		stat_word[ST_WIN] = win_reg;
		stat_word[ST_ACC] = acc_reg;
		stat_word[ST_DATA_LSB +: 8] = last_rd_reg;
		ctrl_wr = wr_pend_reg && (wa_reg == OFF_CTRL);
		start = ctrl_wr && hwdata[CTRL_START_BIT] && !busy_reg;
		wr_pend_next = hready && hsel && htrans[1] && hwrite && (hsize == HSIZE_WORD);
		wa_next = haddr[7:0];
		hrdata_next = 32'h0000_0000;
		if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				OFF_CTRL: hrdata_next = {28'h0000000, cmd_reg};
				OFF_ADDR: hrdata_next = {15'h0000, addr_reg};
				OFF_DATA: hrdata_next = {24'h000000, data_reg};
				OFF_STAT: hrdata_next = stat_word;
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
		cmd_next = start ? hwdata[3:0] : cmd_reg;
		addr_next = (wr_pend_reg && wa_reg == OFF_ADDR && !busy_reg) ? hwdata[16:0] : addr_reg;
		data_next = (wr_pend_reg && wa_reg == OFF_DATA && !busy_reg) ? hwdata[7:0] : data_reg;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wa_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
			cmd_reg <= CMD_READ;
			addr_reg <= 17'h00000;
			data_reg <= 8'h00;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wa_reg <= wa_next;
			hrdata_reg <= hrdata_next;
			cmd_reg <= cmd_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign hrdata = hrdata_reg;

	// ****************************************
	// Command and polling sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		step_next = step_reg;
		issued_next = issued_reg;
		tog_next = tog_reg;
		pre_win_next = pre_win_reg;
		busy_next = busy_reg;
		done_next = done_reg;
		fail_next = fail_reg;
		nacc_next = nacc_reg;
		acc_next = acc_reg;
		win_next = win_reg;
		last_rd_next = last_rd_reg;
		abort_next = abort_reg;
		cyc_start = 1'b0;
		cyc_wr = 1'b0;
		cyc_addr = addr_reg;
		cyc_wdata = 8'h00;
		step_s = seq_step(cmd_reg, step_reg, addr_reg, data_reg);
		if (state_reg != S_IDLE && !issued_reg) begin
			cyc_start = 1'b1;
			issued_next = 1'b1;
		end
		if (cyc_done) issued_next = 1'b0;
		case (state_reg)
			S_IDLE: if (start) begin
				busy_next = 1'b1;
				done_next = 1'b0;
				fail_next = 1'b0;
				nacc_next = 1'b0;
				acc_next = 1'b0;
				abort_next = 1'b0;
				pre_win_next = 1'b0;
				step_next = 3'h0;
				case (hwdata[3:0])
					CMD_READ: state_next = S_READ;
					CMD_ADD: state_next = S_PRE_WIN;
					CMD_POLL: state_next = S_RD1;
					default: state_next = S_SEQ;
				endcase
			end
			S_READ: if (cyc_done) begin
				last_rd_next = cyc_rdata;
				state_next = S_IDLE;
			end
			S_PRE_WIN: if (cyc_done) begin
				pre_win_next = cyc_rdata[ERASE_WINDOW_BIT];
				state_next = S_SEQ;
			end
			S_SEQ: begin
				cyc_wr = 1'b1;
				cyc_addr = step_s.addr;
				cyc_wdata = step_s.data;
				if (cyc_done) begin
					step_next = step_reg + 3'h1;
					if (step_s.last) begin
						if (cmd_reg == CMD_PROG || cmd_reg == CMD_CHIP || accept_cmd(cmd_reg))
							state_next = S_RD1;
						else
							state_next = S_IDLE;
					end
				end
			end
			S_RD1, S_RD3: if (cyc_done) begin
				tog_next = cyc_rdata[ACTIVITY_TOGGLE_BIT];
				last_rd_next = cyc_rdata;
				state_next = (state_reg == S_RD1) ? S_RD2 : S_RD4;
			end
			S_RD2: if (cyc_done) begin
				last_rd_next = cyc_rdata;
				if (accept_cmd(cmd_reg)) begin
					acc_next = cyc_rdata[ACTIVITY_TOGGLE_BIT] != tog_reg;
					state_next = S_POST_WIN;
				end else if (cyc_rdata[ACTIVITY_TOGGLE_BIT] == tog_reg)
					state_next = S_IDLE;
				else if (cyc_rdata[TIMEOUT_FAILURE_FLAG])
					state_next = S_RD3;
				else if (abort_reg)
					state_next = S_IDLE;
				else
					state_next = S_RD1;
			end
			S_RD4: if (cyc_done) begin
				last_rd_next = cyc_rdata;
				if (cyc_rdata[ACTIVITY_TOGGLE_BIT] == tog_reg)
					state_next = S_IDLE;
				else
					state_next = S_RESET;
			end
			S_POST_WIN: if (cyc_done) begin
				win_next = cyc_rdata[ERASE_WINDOW_BIT];
				nacc_next = (cmd_reg == CMD_ADD) && (cyc_rdata[ERASE_WINDOW_BIT] || pre_win_reg);
				state_next = S_IDLE;
			end
			S_RESET: begin
				cyc_wr = 1'b1;
				cyc_addr = ANY_ADDR;
				cyc_wdata = RESET_DATA;
				if (cyc_done) begin
					fail_next = 1'b1;
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
		if (state_reg != S_IDLE && state_next == S_IDLE) begin
			busy_next = 1'b0;
			done_next = 1'b1;
		end
		if (ctrl_wr && hwdata[CTRL_ABORT_BIT] && busy_reg) abort_next = 1'b1;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			step_reg <= 3'h0;
			issued_reg <= 1'b0;
			tog_reg <= 1'b0;
			pre_win_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			nacc_reg <= 1'b0;
			acc_reg <= 1'b0;
			win_reg <= 1'b0;
			last_rd_reg <= 8'h00;
			abort_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			step_reg <= step_next;
			issued_reg <= issued_next;
			tog_reg <= tog_next;
			pre_win_reg <= pre_win_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			nacc_reg <= nacc_next;
			acc_reg <= acc_next;
			win_reg <= win_next;
			last_rd_reg <= last_rd_next;
			abort_reg <= abort_next;
		end
	end

	flash_cycle cycle_u (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(cyc_start),
		.wr(cyc_wr),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.rdata(cyc_rdata),
		.done(cyc_done),
		.pins(flash_out),
		.dq_in(flash_dq_in)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_two_reads: assert property ((state_reg == S_RD1) && cyc_done |=>
		(state_reg == S_RD2) && (tog_reg == $past(cyc_rdata[ACTIVITY_TOGGLE_BIT])))
		else $error("first poll read not followed by second");
	a_fail_recheck: assert property ((state_reg == S_RD2) && cyc_done && !accept_cmd(cmd_reg)
		&& (cyc_rdata[ACTIVITY_TOGGLE_BIT] != tog_reg) && cyc_rdata[TIMEOUT_FAILURE_FLAG]
		|=> state_reg == S_RD3) else $error("failure flag not rechecked");
	a_fail_verdict: assert property ((state_reg == S_RD4) && cyc_done
		&& (cyc_rdata[ACTIVITY_TOGGLE_BIT] != tog_reg) |=> state_reg == S_RESET)
		else $error("toggling after failure not treated as fail");
	a_reset_write: assert property (state_reg == S_RESET && cyc_start |->
		cyc_wr && cyc_wdata == RESET_DATA) else $error("reset command wrong");
	a_fail_flag: assert property ((state_reg == S_RESET) && cyc_done |=>
		fail_reg && done_reg && !busy_reg) else $error("fail not reported after reset");
	a_poll_restart: assert property ((state_reg == S_IDLE) && start
		&& (hwdata[3:0] == CMD_POLL) |=> state_reg == S_RD1) else $error("poll not restarted");
	a_poll_addr: assert property (cyc_start && (state_reg inside {S_RD1, S_RD2, S_RD3, S_RD4})
		|-> cyc_addr == addr_reg) else $error("poll at wrong address");
	a_win_pre: assert property ((state_reg == S_IDLE) && start && (hwdata[3:0] == CMD_ADD)
		|=> state_reg == S_PRE_WIN) else $error("window not checked before sector");
	a_win_post: assert property ((state_reg == S_POST_WIN) && cyc_done |=> nacc_reg ==
		((cmd_reg == CMD_ADD) && ($past(cyc_rdata[ERASE_WINDOW_BIT]) || pre_win_reg)))
		else $error("acceptance verdict wrong");
	a_cycle_bound: assert property (cyc_start |-> ##[3:10] cyc_done) else $error("cycle too long");
	c_poll_ok: cover property ((state_reg == S_RD2) && cyc_done ##1 state_reg == S_IDLE);
	c_fail: cover property ((state_reg == S_RESET) && cyc_done);
	c_not_acc: cover property (nacc_reg && done_reg);
	c_abort: cover property (abort_reg && state_reg == S_RD2 ##1 state_reg == S_IDLE);
endmodule : flash_host
`default_nettype wire

// file: sim/flash_dev_model.sv
// Behavioural model of the boot-sector flash status interface
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
	parameter int PROG_NS = 2000,
	parameter int ERASE_NS = 20000,
	parameter int WIN_NS = 6000,
	parameter int PROT_NS = 2000,
	parameter int PROT_ERASE_NS = 10000,
	parameter logic [4:0] PROT_SECT = 5'h1f
) (
	// Flash pins
	input wire logic [16:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] dq_in,
	// Data driven back
	output logic [7:0] dq_out
);
	logic [7:0] mem [0:131071];
	logic [31:0] sel = '0;
	logic [7:0] q = '0;
	logic [7:0] pv = '0;
	logic busy = 1'b0;
	logic prog = 1'b0;
	logic susp = 1'b0;
	logic fail = 1'b0;
	logic win = 1'b0;
	logic t6 = 1'b0;
	logic t2 = 1'b0;
	int cyc = 0;
	int gen = 0;
	int left;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// Released bus shows the inverse of the last byte
	assign dq_out = (!ce_n && !oe_n) ? q : ~q;
	task automatic erase_run();
		win = 1'b1;
		left = ((sel & ~(32'h1 << PROT_SECT)) != 0) ? ERASE_NS : PROT_ERASE_NS;
		while (left > 0) begin
			#100;
			if (!susp) left -= 100;
		end
		foreach (mem[i]) if (sel[i[16:12]] && i[16:12] != PROT_SECT) mem[i] = 8'hff;
		busy = 1'b0;
		sel = '0;
	endtask : erase_run
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		int g;
		if (d == 8'hf0 && (!busy || fail)) begin
			busy = 1'b0;
			fail = 1'b0;
			cyc = 0;
			return;
		end
		if (busy && win) begin
			if (d == 8'hb0 && !prog) susp = 1'b1;
			else if (d == 8'h30) susp = 1'b0;
			return;
		end
		if (cyc == 3) begin
			cyc = 0;
			busy = 1'b1;
			prog = 1'b1;
			pv = d;
			fork begin
				if (a[16:12] == PROT_SECT) #PROT_NS busy = 1'b0;
				else if ((d & ~mem[a]) != 0) #PROG_NS fail = 1'b1;
				else begin
					#PROG_NS mem[a] = d;
					busy = 1'b0;
				end
			end join_none
			return;
		end
		// Sector command: full sequence, or its last cycle alone inside the window
		if ((cyc == 6 || (busy && !win && sel != 0)) && d == 8'h30) begin
			cyc = 0;
			prog = 1'b0;
			sel[a[16:12]] = 1'b1;
			busy = 1'b1;
			win = 1'b0;
			gen++;
			g = gen;
			fork begin
				#WIN_NS;
				if (g == gen) erase_run();
			end join_none
			return;
		end
		if (cyc == 6) begin
			cyc = 0;
			prog = 1'b0;
			if (d == 8'h10 && !busy) begin
				busy = 1'b1;
				sel = '1;
				fork erase_run(); join_none
			end
			return;
		end
		case (cyc)
			0: cyc = (a[10:0] == 11'h555 && d == 8'haa) ? 1 : 0;
			1: cyc = (a[10:0] == 11'h2aa && d == 8'h55) ? 2 : 0;
			2: cyc = (d == 8'ha0) ? 3 : ((d == 8'h80) ? 4 : 0);
			4: cyc = (d == 8'haa) ? 5 : 0;
			5: cyc = (d == 8'h55) ? 6 : 0;
			default: cyc = 0;
		endcase
	endtask : wr
	always @(negedge oe_n or negedge ce_n) begin
		if (!ce_n && !oe_n) begin
			if (!busy || (susp && !sel[addr[16:12]])) q = mem[addr];
			else begin
				if (!susp) t6 = ~t6;
				if (sel[addr[16:12]]) t2 = ~t2;
				q = {prog ? ~pv[7] : susp, t6, fail, 1'b0, win, t2, 2'b00};
			end
		end
	end
	always @(posedge we_n) if (!ce_n) wr(addr, dq_in);
endmodule : flash_dev_model
`default_nettype wire

// file: sim/tb_flash_host.sv
// Self-checking bench for the flash status-polling host controller
`timescale 1ns/1ps
`default_nettype none
module tb_flash_host;
	import flash_host_pkg::*;
	typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_t;
	logic ref_clk, rst, hsel, hwrite, rd_dp, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd_v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] dev_dq, r;
	logic [7:0] seed = 8'h60;
	flash_pins_t flash_out;
	note_t notes[$];
	int err_total = 0;
	int comparisons = 0;
	wire logic [7:0] bus_dq = flash_out.dq_oe ? flash_out.dq_out : dev_dq;
	flash_host u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .flash_out, .flash_dq_in(bus_dq));
	flash_dev_model u_dev (.addr(flash_out.addr), .ce_n(flash_out.ce_n), .oe_n(flash_out.oe_n),
		.we_n(flash_out.we_n), .dq_in(bus_dq), .dq_out(dev_dq));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] lfsr();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction : lfsr
	task automatic end_sim();
		$display("Counts: %0d mismatches, %0d comparisons", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (e !== s) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm,
		input logic [31:0] e, input logic [31:0] m);
		if (!w) notes.push_back('{nm, e, m});
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd_v = hrdata;
	endtask : ahb
	task automatic run(input logic [3:0] c, input logic [16:0] a, input logic [7:0] d,
		input string nm, input logic [31:0] e, input logic [31:0] m);
		int k;
		ahb(1'b1, OFF_ADDR, {15'h0, a}, "", '0, '0);
		ahb(1'b1, OFF_DATA, {24'h0, d}, "", '0, '0);
		ahb(1'b1, OFF_CTRL, {23'h0, 1'b1, 4'h0, c}, "", '0, '0);
		k = 0;
		do begin
			ahb(1'b0, OFF_STAT, '0, "", '0, '0);
			k++;
		end while (rd_v[ST_BUSY] !== 1'b0 && k < 4000);
		if (k >= 4000) err_total++;
		ahb(1'b0, OFF_STAT, '0, nm, e, m);
		$display("Test %s finished", nm);
	endtask : run
	// Scoreboard: pairs each read data phase with the oldest note
	always @(posedge ref_clk) begin
		note_t n;
		if (rd_dp && hreadyout === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			if (n.m != 0) begin
				chk(n.nm, n.e & n.m, hrdata & n.m);
				chk("hresp", '0, {31'h0, hresp});
			end
		end
		rd_dp = hsel && htrans[1] && !hwrite && hreadyout;
	end
	initial begin
		repeat (80000) @(posedge ref_clk);
		err_total++;
		end_sim();
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = HSIZE_WORD;
		rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		ahb(1'b0, OFF_STAT, '0, "status reset", '0, 32'h0000ffff);
		ahb(1'b0, 8'h40, '0, "unmapped", '0, 32'hffffffff);
		r = lfsr();
		u_dev.mem[17'h01234] = r;
		run(CMD_READ, 17'h01234, 8'h00, "array read", {16'h0, r, 8'h02}, 32'hff0e);
		r = lfsr();
		run(CMD_PROG, 17'h02000, r, "program", 32'h2, 32'he);
		chk("program cell", 32'(r), 32'(u_dev.mem[17'h02000]));
		chk("device idle", '0, 32'(u_dev.busy));
		ahb(1'b1, OFF_ADDR, 32'h0000_2020, "", '0, '0);
		ahb(1'b1, OFF_DATA, {24'h0, r}, "", '0, '0);
		ahb(1'b1, OFF_CTRL, {23'h0, 1'b1, 4'h0, CMD_PROG}, "", '0, '0);
		ahb(1'b1, OFF_CTRL, 32'h0000_0200, "", '0, '0);
		repeat (60) @(posedge ref_clk);
		ahb(1'b0, OFF_STAT, '0, "abort stop", 32'h2, 32'h3);
		chk("abort early", 32'h1, 32'(u_dev.busy));
		run(CMD_POLL, 17'h02020, r, "abort poll", 32'h2, 32'h6);
		chk("abort cell", 32'(r), 32'(u_dev.mem[17'h02020]));
		u_dev.mem[17'h02010] = 8'h00;
		run(CMD_PROG, 17'h02010, 8'hff, "program fail", 32'h6, 32'h6);
		chk("fail cleared", '0, 32'(u_dev.fail | u_dev.busy));
		run(CMD_PROG, 17'h1f000, 8'h00, "protected program", 32'h2, 32'h6);
		chk("protected cell", 32'hff, 32'(u_dev.mem[17'h1f000]));
		u_dev.mem[17'h03005] = r;
		u_dev.mem[17'h1f001] = 8'h00;
		run(CMD_SECT, 17'h02000, 8'h00, "sector erase", '0, 32'h4);
		run(CMD_ADD, 17'h03000, 8'h00, "add sector", '0, 32'hc);
		run(CMD_ADD, 17'h1f000, 8'h00, "add protected", '0, 32'hc);
		run(CMD_POLL, 17'h02000, 8'h00, "erase poll", 32'h2, 32'h6);
		chk("erased cell", 32'hff, 32'(u_dev.mem[17'h03005]));
		chk("protected kept", '0, 32'(u_dev.mem[17'h1f001]));
		run(CMD_SECT, 17'h1f000, 8'h00, "protected erase", '0, 32'h4);
		run(CMD_POLL, 17'h1f000, 8'h00, "protected poll", 32'h2, 32'h6);
		chk("protected intact", '0, 32'(u_dev.mem[17'h1f001]));
		u_dev.mem[17'h06000] = r;
		run(CMD_SECT, 17'h04000, 8'h00, "erase four", '0, 32'h4);
		repeat (400) @(posedge ref_clk);
		run(CMD_ADD, 17'h05000, 8'h00, "late add", 32'h8, 32'h8);
		chk("late sector", '0, 32'(u_dev.sel[5]));
		run(CMD_SUSPEND, 17'h04000, 8'h00, "suspend", '0, 32'h4);
		run(CMD_READ, 17'h06000, 8'h00, "suspend array", {16'h0, r, 8'h0}, 32'hff00);
		run(CMD_READ, 17'h04000, 8'h00, "suspend status", 32'h8000, 32'ha000);
		run(CMD_RESUME, 17'h04000, 8'h00, "resume", '0, 32'h4);
		run(CMD_POLL, 17'h04000, 8'h00, "resume poll", 32'h2, 32'h6);
		run(CMD_CHIP, 17'h00000, 8'h00, "chip erase", 32'h2, 32'h6);
		chk("chip erased", 32'hff, 32'(u_dev.mem[17'h06000]));
		run(CMD_RESET, 17'h00000, 8'h00, "reset", '0, 32'h4);
		end_sim();
	end
endmodule : tb_flash_host
`default_nettype wire
